//--- asd_cpu_model.sv
// Bus master model issuing one access per call
`timescale 1ns/1ps
module asd_cpu_model
(
    input  wire logic   clk_in,
    output logic        req_out,
    output logic        write_out,
    output logic        byte_out,
    output logic        fetch_out,
    output logic [16:0] addr_out,
    output logic [15:0] data_out
);
    initial {req_out, write_out, byte_out, fetch_out, addr_out, data_out} = '0;
    // Request held one clock, then released with address and data inverted
    task issue(input logic w, b, f, input logic [16:0] a, input logic [15:0] dt);
        @(negedge clk_in);
        {req_out, write_out, byte_out, fetch_out, addr_out, data_out} = {1'b1, w, b, f, a, dt};
        @(negedge clk_in);
        req_out = 1'b0;
        addr_out = ~a;
        data_out = ~dt;
    endtask : issue
endmodule : asd_cpu_model

//--- asd_decoder.sv
// Address space decoder with width adaptation for byte and word regions
`timescale 1ns/1ps
`include "asd_map.svh"

// Behaviour
// - One shared address space, shared buses
// - Byte or word transfers per access
// - Decoded space spans 128 kilobytes
// - Flash ends at 0x0FFFF, start configurable
// - Vectors in top sixteen flash words
// - RAM from 0x0200, code and data
// - 0x0100-0x01FF selects word peripherals
// - Byte read of word peripheral: even, high zero
// - 0x010-0x0FF selects byte peripherals
// - Word read of byte peripheral, high undefined
// - Word write to byte peripheral stores low
// - SFRs lowest sixteen bytes, byte access
// - Little-endian words at even addresses
// - Pulse bits: write one pulses, read zero
// - Fetch from peripheral range causes clear
module asd_decoder
    import asd_pkg::*;
#(
    parameter logic [16:0] RAM_BYTES = `ASD_RAM_BYTES,
    parameter logic [16:0] NVM_BYTES = `ASD_NVM_BYTES,
    parameter int          PULSE_W   = 8
)
(
    input  wire logic               REF_CLK_IN,
    input  wire logic               RST_N_IN,
    input  wire logic               REQ_IN,
    input  wire logic               WRITE_IN,
    input  wire logic               BYTE_IN,
    input  wire logic               FETCH_IN,
    input  wire logic [16:0]        MEMORY_ADDRESS_BUS_IN,
    input  wire logic [15:0]        MEMORY_DATA_BUS_WR_IN,
    input  wire logic [15:0]        PERIPH_RDATA_IN,
    input  wire logic [15:0]        MEM_RDATA_IN,
    input  wire logic [PULSE_W-1:0] PULSE_MASK_IN,
    output logic [16:0]             ADDR_OUT,
    output logic [15:0]             WDATA_OUT,
    output logic [1:0]              BYTE_EN_OUT,
    output logic                    WRITE_OUT,
    output logic                    SEL_SFR_OUT,
    output logic                    SEL_P8_OUT,
    output logic                    SEL_P16_OUT,
    output logic                    SEL_RAM_OUT,
    output logic                    SEL_NVM_OUT,
    output logic                    SEL_VEC_OUT,
    output logic [3:0]              VEC_PRIO_OUT,
    output logic [PULSE_W-1:0]      PULSE_OUT,
    output logic [15:0]             MEMORY_DATA_BUS_RD_OUT,
    output logic                    RD_VALID_OUT,
    output logic                    MISALIGN_OUT,
    output logic                    POWER_UP_CLEAR_RESET_OUT
);

    // Region lookup over the single 17-bit byte address space
    function automatic asd_region_t asd_region(input logic [16:0] a);
        asd_region_t r;
        r = ASD_REG_NONE;
        if (a <= `ASD_SFR_LAST)
            r = ASD_REG_SFR;
        else if (a <= `ASD_P8_LAST)
            r = ASD_REG_P8;
        else if (a <= `ASD_P16_LAST)
            r = ASD_REG_P16;
        else if (a < `ASD_RAM_FIRST + RAM_BYTES)
            r = ASD_REG_RAM;
        else if ((a <= `ASD_NVM_LAST) && (a > `ASD_NVM_LAST - NVM_BYTES))
            r = ASD_REG_NVM;
        return r;
    endfunction : asd_region

    asd_region_t region;
    logic        word_odd;
    logic        fetch_bad;
    logic        pulse_hit;
    logic        rd_pend_reg;
    asd_region_t rd_region_reg;
    logic        rd_odd_reg;
    logic        rd_byte_reg;

    // Decode of the current request
    assign region    = asd_region(MEMORY_ADDRESS_BUS_IN);
    assign word_odd  = !BYTE_IN && MEMORY_ADDRESS_BUS_IN[0];
    assign fetch_bad = FETCH_IN && (MEMORY_ADDRESS_BUS_IN <= `ASD_PERIPH_LAST);
    assign pulse_hit = REQ_IN && WRITE_IN && (region == ASD_REG_SFR);

    // One-hot region selects, registered
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            SEL_SFR_OUT <= 1'b0;
            SEL_P8_OUT  <= 1'b0;
            SEL_P16_OUT <= 1'b0;
            SEL_RAM_OUT <= 1'b0;
            SEL_NVM_OUT <= 1'b0;
            SEL_VEC_OUT <= 1'b0;
            VEC_PRIO_OUT <= 4'h0;
        end
        else
        begin
            SEL_SFR_OUT <= REQ_IN && region == ASD_REG_SFR && !fetch_bad;
            SEL_P8_OUT  <= REQ_IN && region == ASD_REG_P8 && !fetch_bad;
            SEL_P16_OUT <= REQ_IN && region == ASD_REG_P16 && !fetch_bad;
            SEL_RAM_OUT <= REQ_IN && region == ASD_REG_RAM;
            SEL_NVM_OUT <= REQ_IN && region == ASD_REG_NVM;
            // Vector table: top sixteen words, 15 = highest priority
            SEL_VEC_OUT <= REQ_IN && region == ASD_REG_NVM
                           && MEMORY_ADDRESS_BUS_IN >= `ASD_VEC_FIRST;
            VEC_PRIO_OUT <= MEMORY_ADDRESS_BUS_IN[4:1];
        end
    end

    // Address, write data and byte lanes toward the regions
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ADDR_OUT    <= 17'h00000;
            WDATA_OUT   <= 16'h0000;
            BYTE_EN_OUT <= 2'h0;
            WRITE_OUT   <= 1'b0;
        end
        else
        begin
            ADDR_OUT  <= {MEMORY_ADDRESS_BUS_IN[16:1], 1'b0};
            WRITE_OUT <= REQ_IN && WRITE_IN && !word_odd && !fetch_bad;
            if (region == ASD_REG_P8 || region == ASD_REG_SFR)
            begin
                // Byte registers: only low byte written
                WDATA_OUT   <= {8'h00, MEMORY_DATA_BUS_WR_IN[7:0]};
                BYTE_EN_OUT <= 2'h1;
            end
            else if (BYTE_IN)
            begin
                // Byte lane chosen by address bit 0
                WDATA_OUT   <= {MEMORY_DATA_BUS_WR_IN[7:0], MEMORY_DATA_BUS_WR_IN[7:0]};
                BYTE_EN_OUT <= MEMORY_ADDRESS_BUS_IN[0] ? 2'h2 : 2'h1;
            end
            else
            begin
                WDATA_OUT   <= MEMORY_DATA_BUS_WR_IN;
                BYTE_EN_OUT <= 2'h3;
            end
        end
    end

    // Strobe bits: pulse one cycle, no storage
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            PULSE_OUT <= '0;
        else
            PULSE_OUT <= pulse_hit ? (MEMORY_DATA_BUS_WR_IN[PULSE_W-1:0] & PULSE_MASK_IN) : '0;
    end

    // Read-side context of the request in flight
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rd_pend_reg   <= 1'b0;
            rd_region_reg <= ASD_REG_NONE;
            rd_odd_reg    <= 1'b0;
            rd_byte_reg   <= 1'b0;
        end
        else
        begin
            rd_pend_reg   <= REQ_IN && !WRITE_IN && !fetch_bad;
            rd_region_reg <= region;
            rd_odd_reg    <= MEMORY_ADDRESS_BUS_IN[0];
            rd_byte_reg   <= BYTE_IN;
        end
    end

    // Read data shaping, one cycle after the selects
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            MEMORY_DATA_BUS_RD_OUT <= 16'h0000;
            RD_VALID_OUT           <= 1'b0;
        end
        else
        begin
            RD_VALID_OUT <= rd_pend_reg;
            unique case (rd_region_reg)
                ASD_REG_SFR, ASD_REG_P8:
                    // High byte undefined for word reads; passed as is
                    MEMORY_DATA_BUS_RD_OUT <= PERIPH_RDATA_IN & ~{8'h00, PULSE_MASK_IN[7:0] & 8'hff};
                ASD_REG_P16:
                    MEMORY_DATA_BUS_RD_OUT <= rd_byte_reg ? {8'h00, PERIPH_RDATA_IN[7:0]}
                                                          : PERIPH_RDATA_IN;
                ASD_REG_RAM, ASD_REG_NVM:
                    MEMORY_DATA_BUS_RD_OUT <= (rd_byte_reg && rd_odd_reg) ? {8'h00, MEM_RDATA_IN[15:8]}
                                            : rd_byte_reg ? {8'h00, MEM_RDATA_IN[7:0]}
                                            : MEM_RDATA_IN;
                default:
                    MEMORY_DATA_BUS_RD_OUT <= 16'h0000;
            endcase
        end
    end

    // Misuse flag and peripheral-fetch clear pulse
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            MISALIGN_OUT             <= 1'b0;
            POWER_UP_CLEAR_RESET_OUT <= 1'b0;
        end
        else
        begin
            MISALIGN_OUT <= REQ_IN && (word_odd
                            || (FETCH_IN && MEMORY_ADDRESS_BUS_IN[0])
                            || (BYTE_IN && region == ASD_REG_P16 && MEMORY_ADDRESS_BUS_IN[0])
                            || (!BYTE_IN && region == ASD_REG_SFR));
            POWER_UP_CLEAR_RESET_OUT <= REQ_IN && fetch_bad;
        end
    end

endmodule : asd_decoder

//--- asd_decoder_tb.sv
// Self-checking testbench for the address space decoder
`timescale 1ns/1ps
module asd_decoder_tb;
    logic REF_CLK_IN = 1'b0, RST_N_IN = 1'b0;
    logic [15:0] PERIPH_RDATA_IN = '0, MEM_RDATA_IN = '0;
    logic [7:0] PULSE_MASK_IN = '0, PULSE_OUT;
    wire logic REQ_IN, WRITE_IN, BYTE_IN, FETCH_IN, WRITE_OUT, SEL_SFR_OUT, SEL_P8_OUT, SEL_P16_OUT, SEL_RAM_OUT;
    wire logic SEL_NVM_OUT, SEL_VEC_OUT, RD_VALID_OUT, MISALIGN_OUT, POWER_UP_CLEAR_RESET_OUT;
    wire logic [16:0] MEMORY_ADDRESS_BUS_IN, ADDR_OUT;
    wire logic [15:0] MEMORY_DATA_BUS_WR_IN, WDATA_OUT, MEMORY_DATA_BUS_RD_OUT;
    wire logic [1:0] BYTE_EN_OUT;
    wire logic [3:0] VEC_PRIO_OUT;
    wire logic [4:0] sel = {SEL_SFR_OUT, SEL_P8_OUT, SEL_P16_OUT, SEL_RAM_OUT, SEL_NVM_OUT};
    int seed = 97, n_mismatch = 0, total_checks = 0;
    logic [31:0] r;
    logic [19:0] tab [22] = '{20'hc0003, 20'h40005, 20'h80020, 20'h00022, 20'h40010, 20'h40104, 20'h40105,
        20'h801fe, 20'hc0201, 20'h003fe, 20'h20200, 20'h00203, 20'h00400, 20'h0c000, 20'h4ffff, 20'h2fffe,
        20'h0ffe0, 20'h20000, 20'h201fe, 20'h00002, 20'h10000, 20'h40009};
    always #10 REF_CLK_IN = ~REF_CLK_IN;
    asd_cpu_model cpu (.clk_in(REF_CLK_IN), .req_out(REQ_IN), .write_out(WRITE_IN), .byte_out(BYTE_IN),
        .fetch_out(FETCH_IN), .addr_out(MEMORY_ADDRESS_BUS_IN), .data_out(MEMORY_DATA_BUS_WR_IN));
    asd_decoder uut (.*);
    // Compare one result against the model
    task chk(input string nm, input logic [16:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Print counts and verdict
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    // One access with its expected region, strobe and read answer
    task acc(input logic w, b, f, input logic [16:0] a);
        logic [15:0] dt, er, mk, ew;
        logic [4:0]  es, rg;
        logic [1:0]  eb;
        logic        ck, bad, vec;
        dt = $random(seed);
        PERIPH_RDATA_IN = $random(seed);
        MEM_RDATA_IN = $random(seed);
        ck = !(f && a <= 17'h1ff);
        // Region by address alone; a peripheral-range fetch selects nothing
        rg = a <= 17'hf ? 5'h10 : a <= 17'hff ? 5'h08 : a <= 17'h1ff ? 5'h04 : a <= 17'h3ff ? 5'h02
            : (a >= 17'hc000 && a <= 17'hffff) ? 5'h01 : 5'h00;
        es = ck ? rg : 5'h00;
        vec = ck && a >= 17'hffe0 && a <= 17'hffff;
        bad = (a[0] && (!b || f || rg[2])) || (!b && rg[4]);
        eb = es[4:3] != 0 ? 2'b01 : !b ? 2'b11 : a[0] ? 2'b10 : 2'b01;
        ew = es[4:3] != 0 ? {8'h00, dt[7:0]} : b ? {2{dt[7:0]}} : dt;
        cpu.issue(w, b, f, a, dt);
        chk("clear", !ck, POWER_UP_CLEAR_RESET_OUT);
        chk("misalign", bad, MISALIGN_OUT);
        chk("vector", vec, SEL_VEC_OUT);
        if (vec) chk("vec_prio", a[4:1], VEC_PRIO_OUT);
        chk("pulse", (w && rg[4]) ? {9'h000, dt[7:0] & PULSE_MASK_IN} : 17'h00000, PULSE_OUT);
        if (!bad) chk("select", es, sel);
        if (!bad && es != 0) chk("addr", {a[16:1], 1'b0}, ADDR_OUT);
        if (!bad && es != 0) chk("write", w, WRITE_OUT);
        if (w && !bad && es != 0) chk("byte_en", eb, BYTE_EN_OUT);
        if (w && !bad && es != 0) chk("wdata", ew, WDATA_OUT);
        @(negedge REF_CLK_IN);
        mk = (es[4:3] != 0 || (b && es[1:0] != 0)) ? 16'h00ff : 16'hffff;
        er = es[4:3] != 0 ? {8'h00, PERIPH_RDATA_IN[7:0] & ~PULSE_MASK_IN}
            : es[2] ? (b ? {8'h00, PERIPH_RDATA_IN[7:0]} : PERIPH_RDATA_IN)
            : es[1:0] == 0 ? 16'h0 : (b && a[0]) ? {8'h00, MEM_RDATA_IN[15:8]} : MEM_RDATA_IN;
        if (!w && ck && !bad) chk("rd_valid", 1'b1, RD_VALID_OUT);
        if (!w && ck && !bad) chk("rdata", er & mk, MEMORY_DATA_BUS_RD_OUT & mk);
    endtask : acc
    // Reset, directed table, then random traffic above the peripherals
    initial
    begin
        PULSE_MASK_IN = $random(seed);
        repeat (3) @(negedge REF_CLK_IN);
        RST_N_IN = 1'b1;
        for (int i = 0; i < 22; i++) acc(tab[i][19], tab[i][18], tab[i][17], tab[i][16:0]);
        repeat (40)
        begin
            r = $random(seed);
            acc(r[17], r[18], 1'b0, r[16:0] | 17'h200);
        end
        stop_test;
    end
endmodule : asd_decoder_tb

//--- asd_map.svh
// Address map constants for the address space decoder
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH

`define ASD_SFR_LAST      17'h0000f
`define ASD_P8_FIRST      17'h00010
`define ASD_P8_LAST       17'h000ff
`define ASD_P16_FIRST     17'h00100
`define ASD_P16_LAST      17'h001ff
`define ASD_RAM_FIRST     17'h00200
`define ASD_NVM_LAST      17'h0ffff
`define ASD_VEC_FIRST     17'h0ffe0
`define ASD_VEC_HIGHEST   17'h0fffe
`define ASD_RAM_BYTES     17'h00200
`define ASD_NVM_BYTES     17'h04000
`define ASD_PERIPH_LAST   17'h001ff

`endif

//--- asd_monitor.sv
// Assertion checker on the address space decoder ports
`timescale 1ns/1ps
module asd_monitor
(
    input wire logic        REF_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        REQ_IN,
    input wire logic        WRITE_IN,
    input wire logic        BYTE_IN,
    input wire logic        FETCH_IN,
    input wire logic [16:0] MEMORY_ADDRESS_BUS_IN,
    input wire logic        SEL_SFR_OUT,
    input wire logic        SEL_P8_OUT,
    input wire logic        SEL_P16_OUT,
    input wire logic        SEL_RAM_OUT,
    input wire logic        SEL_VEC_OUT,
    input wire logic [3:0]  VEC_PRIO_OUT,
    input wire logic        WRITE_OUT,
    input wire logic        MISALIGN_OUT,
    input wire logic        POWER_UP_CLEAR_RESET_OUT,
    input wire logic        RD_VALID_OUT
);
    // Address, data access and alignment shorthand
    wire logic [16:0] a  = MEMORY_ADDRESS_BUS_IN;
    wire logic        d  = REQ_IN && !FETCH_IN;
    wire logic        ok = BYTE_IN || !a[0];
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Selects, clear pulse, misalign flag and read valid tied to the request
    AST_SFR: assert property (d && BYTE_IN && a < 17'h10 |=> SEL_SFR_OUT)
        else $error("sfr sel");
    AST_P8: assert property (d && BYTE_IN && a inside {[17'h10:17'hff]} |=> SEL_P8_OUT)
        else $error("p8 sel");
    AST_P16: assert property (d && !BYTE_IN && ok && a inside {[17'h100:17'h1ff]} |=> SEL_P16_OUT)
        else $error("p16");
    AST_RAM: assert property (REQ_IN && ok && a inside {[17'h200:17'h3ff]} |=> SEL_RAM_OUT)
        else $error("ram sel");
    AST_CLR: assert property (REQ_IN && FETCH_IN && a < 17'h200
        |=> POWER_UP_CLEAR_RESET_OUT && !WRITE_OUT ##1 !RD_VALID_OUT) else $error("clear");
    AST_VEC: assert property (REQ_IN && a inside {[17'hffe0:17'hffff]}
        |=> SEL_VEC_OUT && VEC_PRIO_OUT == $past(a[4:1])) else $error("vector");
    AST_ODD: assert property (REQ_IN && !ok |=> MISALIGN_OUT && !WRITE_OUT)
        else $error("odd word");
    AST_RD: assert property (d && !WRITE_IN && BYTE_IN && a >= 17'h200 |-> ##2 RD_VALID_OUT)
        else $error("rd");
    cover property (POWER_UP_CLEAR_RESET_OUT);
    cover property (SEL_VEC_OUT);
    cover property (MISALIGN_OUT);
endmodule : asd_monitor
bind asd_decoder asd_monitor u_mon (.*);

//--- asd_pkg.sv
// Types for the address space decoder
package asd_pkg;
    typedef enum logic [2:0]
    {
        ASD_REG_NONE,
        ASD_REG_SFR,
        ASD_REG_P8,
        ASD_REG_P16,
        ASD_REG_RAM,
        ASD_REG_NVM
    } asd_region_t;
endpackage : asd_pkg
